// ---- design/serial_port_pkg.sv ----
// Overview of operation
// - Eight-bit frame: start, eight LSB-first, stop.
// - Nine-bit frame adds transmit ninth bit.
// - Writing data buffer starts a transmission only while the transmitter is idle; other writes are ignored.
// - Transmit-done sets at stop bit start.
// - Reception only while receive enable set.
// - Eight-bit accept: done clear, stop checked only when filter set.
// - Failed acceptance changes nothing, no done.
// - Overrun keeps first byte, drops later.
// - Nine-bit: ninth bit stored, address filtered.
// - Interrupt when enabled on either flag.
// - Flags cleared only by software writes.
// - Data address: write transmit, read receive.
// - Second byte shifts while first waits.
// - Bit rate is timer overflow halved.
// - Reload sets overflow at twice bit rate.
// - Receive timer reloads on start edge.
// - Timer clock from six selectable sources.
// - Master sends address ninth bit one.
// - Mode bit zero eight-bit, one nine-bit.
// - Receive-done sets at stop bit sample.
`default_nettype none
package serial_port_pkg;
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_DATA = 2'h1;
  localparam logic [1:0] ADDR_TIMER = 2'h2;
  localparam logic [1:0] ADDR_CLKSEL = 2'h3;
  localparam int BIT_MODE = 7;
  localparam int BIT_UNUSED = 6;
  localparam int BIT_FILTER = 5;
  localparam int BIT_RX_EN = 4;
  localparam int BIT_TX_NINTH = 3;
  localparam int BIT_RX_NINTH = 2;
  localparam int BIT_TX_DONE = 1;
  localparam int BIT_RX_DONE = 0;
  localparam int BIT_TIMER_RUN = 0;
  localparam int BIT_IRQ_EN = 1;
  localparam logic [7:0] CONTROL_RESET = 8'h40;
  localparam logic [2:0] CLK_SYS = 3'h0;
  localparam logic [2:0] CLK_DIV4 = 3'h1;
  localparam logic [2:0] CLK_DIV12 = 3'h2;
  localparam logic [2:0] CLK_DIV48 = 3'h3;
  localparam logic [2:0] CLK_EXT8 = 3'h4;
  localparam logic [2:0] CLK_EXTPIN = 3'h5;
  localparam int DIV4 = 4;
  localparam int DIV12 = 12;
  localparam int DIV48 = 48;
  localparam int DIV8 = 8;
  localparam int TIMER_TOP = 255;
endpackage
`default_nettype wire

// ---- design/serial_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface serial_link_if;
  logic dev_to_far;
  logic far_to_dev;
  modport device (output dev_to_far, input far_to_dev);
  modport far (input dev_to_far, output far_to_dev);
endinterface
`default_nettype wire

// ---- design/serial_port_device.sv ----
`timescale 1ns/1ns
`default_nettype none
module serial_port_device (
  input wire logic clock,
  input wire logic rst,
  serial_link_if.device link,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic ext_osc_tick,
  input wire logic external_timer_input,
  output logic irq
);
  import serial_port_pkg::*;
  typedef enum logic [3:0] {IDLE = 4'b0001, START = 4'b0010, DATA = 4'b0100, STOP = 4'b1000} state_type;
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] rdata_r;
  logic frame_mode_select, address_filter_bit, receive_enable_bit, transmit_ninth_bit;
  logic received_ninth_bit, transmit_done_flag, receive_done_flag;
  logic [7:0] baud_timer_reload, baud_timer_low_byte, rx_timer;
  logic timer_run, irq_en;
  logic [2:0] clk_sel;
  logic [7:0] serial_data_buffer;
  logic [5:0] pre_cnt;
  logic [2:0] ext_cnt;
  logic ext_s1, ext_s2, ext_s3, pin_s1, pin_s2, pin_s3, rx_s1, rx_s2;
  logic tick;
  logic tx_ovf, rx_ovf, tx_half, rx_half;
  logic tx_bit_tick, rx_bit_tick;
  state_type tx_st, rx_st;
  logic [9:0] tx_shift;
  logic [3:0] tx_cnt, rx_cnt;
  logic tx_line;
  logic [8:0] rx_shift;
  logic rx_prev;
  wire wr_ctl = wr && addr == ADDR_CONTROL;
  wire wr_data = wr && addr == ADDR_DATA;
  wire [3:0] tx_len = frame_mode_select ? 4'h9 : 4'h8;
  ////////////////////////////////////////////////////////////////////////////
  // Timer clock source selection.
  wire ext_edge = ext_s2 && !ext_s3;
  wire pin_edge = pin_s2 && !pin_s3;
  always_comb begin
    unique case (clk_sel)
      CLK_SYS: tick = 1'b1;
      CLK_DIV4: tick = pre_cnt % 6'(DIV4) == 6'h0;
      CLK_DIV12: tick = pre_cnt % 6'(DIV12) == 6'h0;
      CLK_DIV48: tick = pre_cnt == 6'h0;
      CLK_EXT8: tick = ext_edge && ext_cnt == 3'h0;
      CLK_EXTPIN: tick = pin_edge;
      default: tick = 1'b0;
    endcase
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      pre_cnt <= 6'h0;
      ext_cnt <= 3'h0;
      {ext_s1, ext_s2, ext_s3, pin_s1, pin_s2, pin_s3, rx_s1, rx_s2} <= 8'hFF;
    end else begin
      pre_cnt <= (pre_cnt == 6'(DIV48 - 1)) ? 6'h0 : pre_cnt + 6'h1;
      if (ext_edge) ext_cnt <= ext_cnt + 3'h1;
      ext_s1 <= ext_osc_tick;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      pin_s1 <= external_timer_input;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      rx_s1 <= link.far_to_dev;
      rx_s2 <= rx_s1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Auto-reload timers; the receive copy restarts at a start edge.
  wire start_edge = rx_st == IDLE && receive_enable_bit && rx_prev && !rx_s2;
  assign tx_ovf = timer_run && tick && baud_timer_low_byte == 8'(TIMER_TOP);
  assign rx_ovf = timer_run && tick && rx_timer == 8'(TIMER_TOP);
  assign tx_bit_tick = tx_ovf && tx_half;
  assign rx_bit_tick = rx_ovf && !rx_half;
  always_ff @(posedge clock) begin
    if (rst) begin
      baud_timer_low_byte <= 8'h0;
      rx_timer <= 8'h0;
      tx_half <= 1'b0;
      rx_half <= 1'b0;
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= rx_s2;
      if (timer_run && tick) begin
        baud_timer_low_byte <= tx_ovf ? baud_timer_reload : baud_timer_low_byte + 8'h1;
        rx_timer <= rx_ovf ? baud_timer_reload : rx_timer + 8'h1;
      end
      if (tx_ovf) tx_half <= !tx_half;
      if (start_edge) begin
        rx_timer <= baud_timer_reload;
        rx_half <= 1'b0;
      end else if (rx_ovf) begin
        rx_half <= !rx_half;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Transmitter.
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_st <= IDLE;
      tx_shift <= 10'h3FF;
      tx_cnt <= 4'h0;
      tx_line <= 1'b1;
    end else begin
      unique case (tx_st)
        IDLE: if (wr_data) begin
          tx_shift <= {1'b1, transmit_ninth_bit, wdata};
          tx_st <= START;
        end
        START: if (tx_bit_tick) begin
          tx_line <= 1'b0;
          tx_cnt <= 4'h0;
          tx_st <= DATA;
        end
        DATA: if (tx_bit_tick) begin
          tx_line <= tx_shift[0];
          tx_shift <= {1'b1, tx_shift[9:1]};
          tx_cnt <= tx_cnt + 4'h1;
          if (tx_cnt + 4'h1 == tx_len) tx_st <= STOP;
        end
        STOP: if (tx_bit_tick) begin
          tx_line <= 1'b1;
          tx_st <= IDLE;
        end
      endcase
    end
  end
  assign link.dev_to_far = tx_line;
  wire tx_done_set = tx_st == STOP && tx_bit_tick;
  ////////////////////////////////////////////////////////////////////////////
  // Receiver, sampling at bit centres.
  wire accept_cond = !receive_done_flag && (frame_mode_select ? (!address_filter_bit || rx_shift[8])
                      : (!address_filter_bit || rx_s2));
  wire rx_done_set = rx_st == STOP && rx_bit_tick && accept_cond;
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_st <= IDLE;
      rx_cnt <= 4'h0;
      rx_shift <= 9'h0;
      serial_data_buffer <= 8'h0;
      received_ninth_bit <= 1'b0;
    end else begin
      unique case (rx_st)
        IDLE: if (start_edge) rx_st <= START;
        START: if (rx_bit_tick) begin
          rx_st <= rx_s2 ? IDLE : DATA;
          rx_cnt <= 4'h0;
        end
        DATA: if (rx_bit_tick) begin
          rx_shift <= frame_mode_select ? {rx_s2, rx_shift[8:1]} : {1'b0, rx_s2, rx_shift[7:1]};
          rx_cnt <= rx_cnt + 4'h1;
          if (rx_cnt + 4'h1 == tx_len) rx_st <= STOP;
        end
        STOP: if (rx_bit_tick) begin
          rx_st <= IDLE;
          if (rx_done_set) begin
            serial_data_buffer <= rx_shift[7:0];
            received_ninth_bit <= frame_mode_select ? rx_shift[8] : rx_s2;
          end
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Registers; hardware set beats software clear.
  always_ff @(posedge clock) begin
    if (rst) begin
      {frame_mode_select, address_filter_bit, receive_enable_bit, transmit_ninth_bit} <= 4'h0;
      transmit_done_flag <= 1'b0;
      receive_done_flag <= 1'b0;
      baud_timer_reload <= 8'h0;
      timer_run <= 1'b0;
      irq_en <= 1'b0;
      clk_sel <= CLK_SYS;
      rdata_r <= 8'h0;
    end else begin
      if (wr_ctl) begin
        frame_mode_select <= wdata[BIT_MODE];
        address_filter_bit <= wdata[BIT_FILTER];
        receive_enable_bit <= wdata[BIT_RX_EN];
        transmit_ninth_bit <= wdata[BIT_TX_NINTH];
      end
      if (tx_done_set) transmit_done_flag <= 1'b1;
      else if (wr_ctl) transmit_done_flag <= wdata[BIT_TX_DONE];
      if (rx_done_set) receive_done_flag <= 1'b1;
      else if (wr_ctl) receive_done_flag <= wdata[BIT_RX_DONE];
      if (wr && addr == ADDR_TIMER) baud_timer_reload <= wdata;
      if (wr && addr == ADDR_CLKSEL) begin
        clk_sel <= wdata[4:2];
        irq_en <= wdata[BIT_IRQ_EN];
        timer_run <= wdata[BIT_TIMER_RUN];
      end
      if (rd) begin
        unique case (addr)
          ADDR_CONTROL: rdata_r <= {frame_mode_select, 1'b1, address_filter_bit, receive_enable_bit,
                                    transmit_ninth_bit, received_ninth_bit, transmit_done_flag, receive_done_flag};
          ADDR_DATA: rdata_r <= serial_data_buffer;
          ADDR_TIMER: rdata_r <= baud_timer_reload;
          ADDR_CLKSEL: rdata_r <= {3'h0, clk_sel, irq_en, timer_run};
        endcase
      end
    end
  end
  assign rdata = rdata_r;
  assign irq = irq_en && (transmit_done_flag || receive_done_flag);
endmodule // serial_port_device
`default_nettype wire

// ---- design/serial_port_far.sv ----
`timescale 1ns/1ns
`default_nettype none
module serial_port_far #(
  parameter int CYCLES_PER_BIT = 16
) (
  input wire logic clock,
  input wire logic rst,
  serial_link_if.far link,
  input wire logic nine_bit_mode,
  input wire logic [8:0] send_data,
  input wire logic send_valid,
  output logic send_ready,
  output logic [8:0] recv_data,
  output logic recv_valid
);
  import serial_port_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  logic [10:0] tx_sh_r;
  logic [3:0] tx_left_r;
  logic [15:0] tx_cnt_r, rx_cnt_r;
  logic rx_s1, rx_s2, rx_busy_r;
  logic [3:0] rx_idx_r;
  logic [9:0] rx_sh_r;
  logic [8:0] recv_data_r;
  logic recv_valid_r, line_r;
  wire [3:0] frame_bits = nine_bit_mode ? 4'hB : 4'hA;
  assign send_ready = tx_left_r == 4'h0;
  assign link.far_to_dev = line_r;
  assign recv_data = recv_data_r;
  assign recv_valid = recv_valid_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_sh_r <= 11'h7FF;
      tx_left_r <= 4'h0;
      tx_cnt_r <= 16'h0;
      line_r <= 1'b1;
    end else if (send_valid && send_ready) begin
      tx_sh_r <= nine_bit_mode ? {1'b1, send_data, 1'b0} : {2'b11, send_data[7:0], 1'b0};
      tx_left_r <= frame_bits;
      tx_cnt_r <= 16'h0;
    end else if (tx_left_r != 4'h0) begin
      line_r <= tx_sh_r[0];
      if (tx_cnt_r == 16'(CYCLES_PER_BIT - 1)) begin
        tx_cnt_r <= 16'h0;
        tx_sh_r <= {1'b1, tx_sh_r[10:1]};
        tx_left_r <= tx_left_r - 4'h1;
      end else begin
        tx_cnt_r <= tx_cnt_r + 16'h1;
      end
    end else begin
      line_r <= 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      {rx_s1, rx_s2} <= 2'h3;
      rx_busy_r <= 1'b0;
      rx_idx_r <= 4'h0;
      rx_cnt_r <= 16'h0;
      rx_sh_r <= 10'h0;
      recv_data_r <= 9'h0;
      recv_valid_r <= 1'b0;
    end else begin
      rx_s1 <= link.dev_to_far;
      rx_s2 <= rx_s1;
      recv_valid_r <= 1'b0;
      if (!rx_busy_r) begin
        if (!rx_s2) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r <= 16'(CYCLES_PER_BIT / 2);
          rx_idx_r <= 4'h0;
        end
      end else if (rx_cnt_r == 16'(CYCLES_PER_BIT - 1)) begin
        rx_cnt_r <= 16'h0;
        rx_sh_r <= {rx_s2, rx_sh_r[9:1]};
        rx_idx_r <= rx_idx_r + 4'h1;
        if (rx_idx_r + 4'h1 == frame_bits) begin
          rx_busy_r <= 1'b0;
          recv_valid_r <= 1'b1;
          recv_data_r <= nine_bit_mode ? rx_sh_r[9:1] : {1'b0, rx_sh_r[9:2]};
        end
      end else begin
        rx_cnt_r <= rx_cnt_r + 16'h1;
      end
    end
  end
endmodule // serial_port_far
`default_nettype wire

// ---- verification/serial_port_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module serial_port_props
  import serial_port_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic dev_to_far,
  input wire logic far_to_dev,
  input wire logic [1:0] addr,
  input wire logic wr,
  input wire logic send_valid,
  input wire logic send_ready,
  input wire logic recv_valid,
  input wire logic irq
);
  // Counts idle line cycles, saturating, so a data write is known to meet an idle transmitter.
  logic [8:0] idle_r;
  logic [8:0] idle_nxt;
  assign idle_nxt = !dev_to_far ? 9'h000 : idle_r + {8'h00, idle_r != 9'h12C};
  always_ff @(posedge clock) begin
    if (rst) begin
      idle_r <= 9'h12C;
    end else begin
      idle_r <= idle_nxt;
    end
  end
  ////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  chk_idle_lines: assert property ($fell(rst) |-> dev_to_far && far_to_dev)
    else $error("line not idle after reset");
  chk_dev_start_len: assert property ($fell(dev_to_far) |-> !dev_to_far [*8])
    else $error("device bit too short");
  chk_far_start_len: assert property ($fell(far_to_dev) |-> !far_to_dev [*8])
    else $error("far bit too short");
  chk_far_sends: assert property (send_valid && send_ready |-> ##[1:20] !far_to_dev)
    else $error("far frame not started");
  chk_write_starts_tx: assert property (wr && addr == ADDR_DATA && idle_r > 9'h0C8 |-> ##[1:800] !dev_to_far)
    else $error("data write sent nothing");
  chk_stop_at_recv: assert property (recv_valid |-> dev_to_far)
    else $error("stop bit not high");
  chk_irq_rise_cause: assert property ($rose(irq) |-> $past(wr) || dev_to_far || far_to_dev)
    else $error("interrupt without cause");
  chk_irq_fall_write: assert property ($fell(irq) |-> $past(wr))
    else $error("flag cleared by hardware");
  cov_dev_frame: cover property ($fell(dev_to_far));
  cov_far_recv: cover property (recv_valid);
  cov_irq: cover property ($rose(irq));
endmodule // serial_port_props
`default_nettype wire

// ---- verification/async_serial_port_with_timer_baud_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module async_serial_port_with_timer_baud_test;
  import serial_port_pkg::*;
  localparam int CPB = 16;
  logic clock, rst, wr, rd, osc, tin, nine, s_valid, s_ready, r_valid, irq, rx9, rdone, txd;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, v, ctl, latch;
  logic [8:0] sd, r_data;
  logic [8:0] tx_q[$];
  int n_errors, checked;
  serial_link_if serial_link_if_i ();
  serial_port_device serial_port_device_i (.clock(clock), .rst(rst), .link(serial_link_if_i.device), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_osc_tick(osc), .external_timer_input(tin), .irq(irq));
  serial_port_far #(.CYCLES_PER_BIT(CPB)) serial_port_far_i (.clock(clock), .rst(rst), .link(serial_link_if_i.far),
    .nine_bit_mode(nine), .send_data(sd), .send_valid(s_valid), .send_ready(s_ready), .recv_data(r_data),
    .recv_valid(r_valid));
  serial_port_props serial_port_props_i (.clock(clock), .rst(rst), .dev_to_far(serial_link_if_i.dev_to_far),
    .far_to_dev(serial_link_if_i.far_to_dev), .addr(addr), .wr(wr), .send_valid(s_valid), .send_ready(s_ready),
    .recv_valid(r_valid), .irq(irq));
  ////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) {osc, tin} <= 2'($urandom);
  always @(negedge clock) begin
    if (r_valid === 1'b1) begin
      `CHK(r_data[7:0], tx_q[0][7:0])
      if (nine) `CHK(r_data[8], tx_q[0][8])
      void'(tx_q.pop_front());
    end
  end
  task automatic finish_test();
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] q);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic set_ctl(input logic [7:0] c);
    ctl = {c[7:3], rx9, 2'b00};
    {txd, rdone} = 2'h0;
    wr_reg(ADDR_CONTROL, ctl);
  endtask
  task automatic chk_ctl();
    `CHK(serial_link_if_i.dev_to_far, 1'b1)
    rd_reg(ADDR_DATA, v);
    `CHK(v, latch)
    rd_reg(ADDR_CONTROL, v);
    `CHK(v, {ctl[7], 1'b1, ctl[5:3], rx9, txd, rdone})
    `CHK(irq, txd | rdone)
  endtask
  task automatic dev_tx(input logic [7:0] b);
    tx_q.push_back({ctl[3], b});
    wr_reg(ADDR_DATA, b);
    for (int i = 0; i < 2000 && tx_q.size() > 0; i++) @(posedge clock);
    repeat (2 * CPB) @(posedge clock);
    txd = 1'b1;
    chk_ctl();
  endtask
  task automatic far_tx(input logic [8:0] d);
    logic ok;
    ok = ctl[4] && !rdone && (!ctl[5] || !ctl[7] || d[8]);
    @(posedge clock);
    `CHK(s_ready, 1'b1)
    sd <= d;
    s_valid <= 1'b1;
    @(posedge clock);
    s_valid <= 1'b0;
    repeat (13 * CPB) @(posedge clock);
    if (ok) {rdone, rx9, latch} = {1'b1, !ctl[7] | d[8], d[7:0]};
    chk_ctl();
  endtask
  initial begin
    void'($urandom(32'hED9C));
    rst = 1'b1;
    {wr, rd, s_valid, nine} = 4'h0;
    {addr, wdata, sd} = 19'h00000;
    {rx9, rdone, txd, latch, ctl} = 19'h00000;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd_reg(ADDR_CONTROL, v);
    `CHK(v, CONTROL_RESET)
    wr_reg(ADDR_CLKSEL, 8'h03);
    wr_reg(ADDR_TIMER, 8'hF8);
    set_ctl(8'h10);
    dev_tx(8'($urandom));
    set_ctl(8'h10);
    far_tx({1'b0, 8'($urandom)});
    far_tx({1'b0, 8'($urandom)});
    set_ctl(8'h00);
    far_tx(9'h0A5);
    set_ctl(8'h30);
    far_tx(9'h0FF);
    @(posedge clock) nine <= 1'b1;
    set_ctl(8'hB0);
    far_tx({1'b0, 8'($urandom)});
    far_tx({1'b1, 8'($urandom)});
    set_ctl(8'h90);
    far_tx({1'b0, 8'($urandom)});
    set_ctl(8'h98);
    dev_tx(8'($urandom));
    set_ctl(8'h90);
    dev_tx(8'h00);
    @(posedge clock) nine <= 1'b0;
    set_ctl(8'h10);
    wr_reg(ADDR_TIMER, 8'hFE);
    wr_reg(ADDR_CLKSEL, 8'h07);
    dev_tx(8'h80);
    far_tx(9'h001);
    `CHK(tx_q.size(), 0)
    finish_test();
  end
  initial begin
    repeat (30000) @(posedge clock);
    n_errors++;
    finish_test();
  end
endmodule // async_serial_port_with_timer_baud_test
`default_nettype wire
